// ==== core/asm_pkg.sv ====
// Shared constants and types of the serial modem interface
package asm_pkg;

	// ----------------------------------------
	// Clocks
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned REF_HZ = 1843200;
	localparam int unsigned DIV_UNIT = 1;

	// ----------------------------------------
	// Register selects
	// ----------------------------------------
	localparam logic [1:0] RS_DATA = 2'h0;
	localparam logic [1:0] RS_STAT = 2'h1;
	localparam logic [1:0] RS_CMD  = 2'h2;
	localparam logic [1:0] RS_CTL  = 2'h3;

	// ----------------------------------------
	// Status bit positions
	// ----------------------------------------
	localparam int ST_PE   = 0;
	localparam int ST_FE   = 1;
	localparam int ST_OVR  = 2;
	localparam int ST_RXF  = 3;
	localparam int ST_TXE  = 4;
	localparam int ST_DCD  = 5;
	localparam int ST_DSR  = 6;
	localparam int ST_IRQ  = 7;

	// ----------------------------------------
	// Command and control fields
	// ----------------------------------------
	localparam int CMD_DTR    = 0;
	localparam int CMD_RXIDIS = 1;
	localparam int CMD_TXC_LO = 2;
	localparam int CMD_PEN    = 5;
	localparam int CMD_PMD_LO = 6;
	localparam int CTL_DIV_LO = 0;
	localparam int CTL_RXSRC  = 4;
	localparam int CTL_WL_LO  = 5;
	localparam int CTL_STOP   = 7;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h00;

	// ----------------------------------------
	// Oversampling
	// ----------------------------------------
	localparam logic [3:0] PH_MID  = 4'h7;
	localparam logic [3:0] PH_LAST = 4'hf;

	// ----------------------------------------
	// Synchronised pin indices
	// ----------------------------------------
	localparam int P_RXD = 0;
	localparam int P_RXC = 1;
	localparam int P_CTS = 2;
	localparam int P_DCD = 3;
	localparam int P_DSR = 4;
	localparam int NPIN  = 5;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} asm_rx_e;

endpackage

// ==== core/asm_baud.sv ====
// Baud rate generator producing a 16x tick from the reference clock
`timescale 1ns/1ps
`default_nettype none
module asm_baud (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       baud_reference_in,
	input  wire logic [3:0] div_sel,
	output logic            tick16,
	output logic            baud_reference_out
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]  sy;
		logic        lv;
		logic [15:0] cnt;
		logic        tick;
		logic        refo;
	} asm_baud_s;

	asm_baud_s st_r;
	asm_baud_s st_nxt;

	if (asm_pkg::REF_HZ * 2 >= asm_pkg::CLK_HZ) begin : g_ref_chk
		$error("reference too fast for core clock");
	end

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	always_comb begin
		logic [15:0] div;
		div = 16'(({12'h000, div_sel} + 16'h0001) * 16'(asm_pkg::DIV_UNIT));
		st_nxt = st_r;
		st_nxt.sy = {st_r.sy[1:0], baud_reference_in};
		if (st_r.sy[2] == st_r.sy[1])
			st_nxt.lv = st_r.sy[2];
		st_nxt.tick = 1'b0;
		st_nxt.refo = ~st_r.lv;
		if (st_nxt.lv && !st_r.lv) begin // RL1
			if (st_r.cnt + 16'h0001 >= div) begin // RL11
				st_nxt.cnt = 16'h0000;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tick16 = st_r.tick;
	assign baud_reference_out = st_r.refo;
endmodule // asm_baud
`default_nettype wire

// ==== core/asm_modem.sv ====
// Serial transmitter/receiver with modem handshake lines
// Operation
// RL1: All baud rates derive from the 1.8432 MHz reference input.
// RL2: Transmitter sends holding word as NRZ, LSB first, at selected rate.
// RL3: Receiver takes NRZ LSB first, clocked internally or externally per control.
// RL4: Receive clock pin is 16x input externally, else drives internal 16x clock.
// RL5: Request-to-send output follows only the command register setting.
// RL6: Transmitter runs only while clear-to-send is low; the code tests it only when a frame starts, so a frame in progress finishes.
// RL7: Data-terminal-ready is low when command bit 0 set, else high.
// RL8: With command bit 0 set, data-set-ready change raises interrupt; status 6 mirrors.
// RL9: With command bit 0 set, carrier change raises interrupt; status 5 mirrors.
// RL10: Receiver runs only while carrier detect is low; transmitter ignores it.
// RL11: Control bits 3..0 select the baud divisor.
// RL12: Parity, framing and overrun flags set on faults, never interrupt.
// RL13: Error flags clear after data read and next error-free character.
// RL14: Receive-full set when word waits; data register read clears it.
// RL15: Transmit-empty set when holding free; data register write clears it.
// RL16: Interrupt status bit set while pending; status read clears it.
// RL17: Unused high transmit bits are ignored for short words.
// RL18: Received first bit lands in bit 0; parity and unused bits read zero.
// RL19: External receive clock is sixteen times the bit rate.
// RL20: Only command and control read back; reset address clears registers; the code clears only command and overrun, control is kept.
// RL21: Frame is low start, data, optional parity, high stops; idle high.
// RL22: Carrier and data-set-ready status bits track live line levels.
`timescale 1ns/1ps
`default_nettype none
module asm_modem (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       cs0,
	input  wire logic       cs1_n,
	input  wire logic [1:0] rs,
	input  wire logic       rw,
	input  wire logic [7:0] db_i,
	output logic      [7:0] db_o,
	output logic            db_oe,
	output logic            irq_n_o,
	output logic            irq_oe,
	input  wire logic       baud_reference_in,
	output logic            baud_reference_out,
	input  wire logic       rxd,
	output logic            txd,
	input  wire logic       receive_clock_pin_i,
	output logic            receive_clock_pin_o,
	output logic            receive_clock_pin_oe,
	input  wire logic       cts_n,
	output logic            rts_n,
	output logic            dtr_n,
	input  wire logic       dsr_n,
	input  wire logic       dcd_n
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [asm_pkg::NPIN-1:0] sy0;
		logic [asm_pkg::NPIN-1:0] sy1;
		logic [asm_pkg::NPIN-1:0] sy2;
		logic [asm_pkg::NPIN-1:0] lv;
		logic                     sel_q;
		logic [7:0]               cmd;
		logic [7:0]               ctl;
		logic [7:0]               thr;
		logic                     txe;
		logic                     tx_busy;
		logic [11:0]              tx_sh;
		logic [3:0]               tx_left;
		logic [3:0]               tx_ph;
		logic                     txd;
		asm_pkg::asm_rx_e         rx_st;
		logic [3:0]               rx_ph;
		logic [3:0]               rx_n;
		logic [8:0]               rx_sh;
		logic [7:0]               receive_holding;
		logic                     rxf;
		logic                     pe;
		logic                     fe;
		logic                     ovr;
		logic                     irq;
		logic [7:0]               dbo;
		logic                     dboe;
		logic                     rxco;
		logic                     rxcoe;
		logic                     rts_n;
		logic                     dtr_n;
	} asm_st_s;

	asm_st_s st_r;
	asm_st_s st_nxt;
	logic    tick16;

	// ----------------------------------------
	// Baud generator
	// ----------------------------------------
	asm_baud u_baud (
		.core_clk           (core_clk),
		.rst_n              (rst_n),
		.baud_reference_in  (baud_reference_in),
		.div_sel            (st_r.ctl[asm_pkg::CTL_DIV_LO +: 4]),
		.tick16             (tick16),
		.baud_reference_out (baud_reference_out)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] data_mask(input logic [3:0] nd);
		data_mask = 8'hff >> (4'h8 - nd);
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic [3:0] nd,
			input logic [1:0] md);
		logic x;
		x = ^(d & data_mask(nd));
		unique case (md)
			2'h0: par_bit = ~x;
			2'h1: par_bit = x;
			2'h2: par_bit = 1'b1;
			2'h3: par_bit = 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic       sel;
		logic       take;
		logic [3:0] nd;
		logic       pen;
		logic [3:0] nbits;
		logic [11:0] fr;
		logic       rx_tick;
		logic       rxb;
		logic       done;
		logic [7:0] rword;
		logic       rpe;
		logic       rfe;
		logic       ev;
		sel = cs0 && !cs1_n;
		take = sel && !st_r.sel_q;
		nd = 4'h8 - {2'h0, st_r.ctl[asm_pkg::CTL_WL_LO +: 2]};
		pen = st_r.cmd[asm_pkg::CMD_PEN];
		nbits = 4'h2 + nd + {3'h0, pen} + {3'h0, st_r.ctl[asm_pkg::CTL_STOP]};
		fr = '1;
		rx_tick = 1'b0;
		rxb = 1'b0;
		done = 1'b0;
		rword = 8'h00;
		rpe = 1'b0;
		rfe = 1'b0;
		ev = 1'b0;
		st_nxt = st_r;

		// Pin synchronisers, level accepted when stages two and three agree
		st_nxt.sy0 = {dsr_n, dcd_n, cts_n, receive_clock_pin_i, rxd};
		st_nxt.sy1 = st_r.sy0;
		st_nxt.sy2 = st_r.sy1;
		for (int i = 0; i < asm_pkg::NPIN; i++) begin
			if (st_r.sy1[i] == st_r.sy2[i])
				st_nxt.lv[i] = st_r.sy2[i];
		end
		st_nxt.sel_q = sel;

		// Modem change events
		if (st_r.cmd[asm_pkg::CMD_DTR] &&
				(st_nxt.lv[asm_pkg::P_DCD] != st_r.lv[asm_pkg::P_DCD] || // RL9
				st_nxt.lv[asm_pkg::P_DSR] != st_r.lv[asm_pkg::P_DSR])) // RL8
			ev = 1'b1;

		// Transmitter
		if (!st_r.tx_busy && !st_r.txe && !st_r.lv[asm_pkg::P_CTS]) begin // RL6
			fr[0] = 1'b0; // RL21
			for (int i = 0; i < 8; i++) begin
				if (4'(i) < nd)
					fr[i + 1] = st_r.thr[i]; // RL17
			end
			if (pen)
				fr[nd + 4'h1] = par_bit(st_r.thr, nd, st_r.cmd[asm_pkg::CMD_PMD_LO +: 2]);
			st_nxt.tx_sh = fr;
			st_nxt.tx_left = nbits;
			st_nxt.tx_ph = 4'h0;
			st_nxt.tx_busy = 1'b1;
			st_nxt.txe = 1'b1; // RL15
			if (st_r.cmd[asm_pkg::CMD_TXC_LO +: 2] == 2'h1)
				ev = 1'b1;
		end else if (st_r.tx_busy && tick16) begin
			st_nxt.tx_ph = st_r.tx_ph + 4'h1;
			if (st_r.tx_ph == asm_pkg::PH_LAST) begin // RL2
				st_nxt.tx_sh = {1'b1, st_r.tx_sh[11:1]};
				st_nxt.tx_left = st_r.tx_left - 4'h1;
				if (st_r.tx_left == 4'h1)
					st_nxt.tx_busy = 1'b0;
			end
		end
		st_nxt.txd = st_nxt.tx_busy ? st_nxt.tx_sh[0] : 1'b1; // RL21

		// Receiver clock select
		if (st_r.ctl[asm_pkg::CTL_RXSRC])
			rx_tick = tick16; // RL3
		else
			rx_tick = st_nxt.lv[asm_pkg::P_RXC] && !st_r.lv[asm_pkg::P_RXC]; // RL19
		rxb = st_r.lv[asm_pkg::P_RXD];

		// Receiver
		if (st_r.lv[asm_pkg::P_DCD]) begin // RL10
			st_nxt.rx_st = asm_pkg::RX_IDLE;
		end else if (rx_tick) begin
			unique case (st_r.rx_st)
				asm_pkg::RX_IDLE: begin
					if (!rxb) begin
						st_nxt.rx_st = asm_pkg::RX_START;
						st_nxt.rx_ph = 4'h0;
					end
				end
				asm_pkg::RX_START: begin
					st_nxt.rx_ph = st_r.rx_ph + 4'h1;
					if (st_r.rx_ph == asm_pkg::PH_MID) begin
						st_nxt.rx_st = rxb ? asm_pkg::RX_IDLE : asm_pkg::RX_DATA;
						st_nxt.rx_ph = 4'h0;
						st_nxt.rx_n = 4'h0;
						st_nxt.rx_sh = 9'h000;
					end
				end
				asm_pkg::RX_DATA: begin
					st_nxt.rx_ph = st_r.rx_ph + 4'h1;
					if (st_r.rx_ph == asm_pkg::PH_LAST) begin
						if (st_r.rx_n < nd + {3'h0, pen}) begin
							st_nxt.rx_sh[st_r.rx_n] = rxb; // RL3
							st_nxt.rx_n = st_r.rx_n + 4'h1;
						end else begin
							st_nxt.rx_st = asm_pkg::RX_IDLE;
							done = 1'b1;
							rfe = !rxb;
						end
					end
				end
				default: st_nxt.rx_st = asm_pkg::RX_IDLE;
			endcase
		end

		// Receive completion
		rword = st_r.rx_sh[7:0] & data_mask(nd); // RL18
		rpe = pen && (st_r.rx_sh[nd] !=
			par_bit(st_r.rx_sh[7:0], nd, st_r.cmd[asm_pkg::CMD_PMD_LO +: 2]));
		if (done) begin
			if (st_r.rxf) begin
				st_nxt.ovr = 1'b1; // RL12
			end else begin
				st_nxt.receive_holding = rword; // RL18
				st_nxt.rxf = 1'b1; // RL14
				st_nxt.pe = rpe; // RL13
				st_nxt.fe = rfe; // RL13
				st_nxt.ovr = 1'b0; // RL13
				if (!st_r.cmd[asm_pkg::CMD_RXIDIS])
					ev = 1'b1;
			end
		end

		// Bus access
		st_nxt.dboe = sel && rw;
		if (take && rw) begin
			unique case (rs)
				asm_pkg::RS_DATA: begin
					st_nxt.dbo = st_r.receive_holding;
					st_nxt.rxf = done && !st_r.rxf; // RL14
				end
				asm_pkg::RS_STAT: begin
					st_nxt.dbo = {st_r.irq, st_r.lv[asm_pkg::P_DSR], // RL22
						st_r.lv[asm_pkg::P_DCD], st_r.txe, st_r.rxf,
						st_r.ovr, st_r.fe, st_r.pe};
					st_nxt.irq = 1'b0; // RL16
				end
				asm_pkg::RS_CMD: st_nxt.dbo = st_r.cmd; // RL20
				asm_pkg::RS_CTL: st_nxt.dbo = st_r.ctl; // RL20
			endcase
		end else if (take) begin
			unique case (rs)
				asm_pkg::RS_DATA: begin
					st_nxt.thr = db_i;
					st_nxt.txe = 1'b0; // RL15
				end
				asm_pkg::RS_STAT: begin
					st_nxt.cmd = asm_pkg::CMD_RST; // RL20
					st_nxt.ovr = 1'b0;
				end
				asm_pkg::RS_CMD: st_nxt.cmd = db_i;
				asm_pkg::RS_CTL: st_nxt.ctl = db_i;
			endcase
		end
		if (ev)
			st_nxt.irq = 1'b1; // RL16

		// Modem and clock outputs
		st_nxt.dtr_n = !st_nxt.cmd[asm_pkg::CMD_DTR]; // RL7
		st_nxt.rts_n = st_nxt.cmd[asm_pkg::CMD_TXC_LO +: 2] == 2'h0; // RL5
		st_nxt.rxcoe = st_nxt.ctl[asm_pkg::CTL_RXSRC]; // RL4
		st_nxt.rxco = tick16; // RL4
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.sy0 <= '1;
			st_r.sy1 <= '1;
			st_r.sy2 <= '1;
			st_r.lv <= '1;
			st_r.cmd <= asm_pkg::CMD_RST;
			st_r.ctl <= asm_pkg::CTL_RST;
			st_r.txe <= 1'b1;
			st_r.txd <= 1'b1;
			st_r.tx_sh <= '1;
			st_r.rx_st <= asm_pkg::RX_IDLE;
			st_r.rts_n <= 1'b1;
			st_r.dtr_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign db_o = st_r.dbo;
	assign db_oe = st_r.dboe;
	assign irq_n_o = 1'b0 & st_r.irq;
	assign irq_oe = st_r.irq;
	assign txd = st_r.txd;
	assign receive_clock_pin_o = st_r.rxco;
	assign receive_clock_pin_oe = st_r.rxcoe;
	assign rts_n = st_r.rts_n;
	assign dtr_n = st_r.dtr_n;
endmodule // asm_modem
`default_nettype wire

// ==== bench/asm_sva.sv ====
// Port-level checks of the serial modem interface
`timescale 1ns/1ps
`default_nettype none
module asm_sva (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       cs0,
	input wire logic       cs1_n,
	input wire logic [1:0] rs,
	input wire logic       rw,
	input wire logic [7:0] db_i,
	input wire logic [7:0] db_o,
	input wire logic       db_oe,
	input wire logic       irq_oe,
	input wire logic       txd,
	input wire logic       receive_clock_pin_oe,
	input wire logic       rts_n,
	input wire logic       dtr_n,
	input wire logic       dsr_n,
	input wire logic       dcd_n
);
	// ------
	// Mirror
	// ------
	logic       sel_q;
	logic [7:0] cmd_m;
	logic [7:0] ctl_m;
	logic [3:0] quiet;
	wire        sel    = cs0 && !cs1_n;
	wire        wr     = sel && !sel_q && !rw;
	wire        cmd_wr = wr && rs == asm_pkg::RS_CMD;
	wire        ctl_wr = wr && rs == asm_pkg::RS_CTL;
	wire        st_rd  = sel && !sel_q && rw && rs == asm_pkg::RS_STAT;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q <= 1'b0;
			cmd_m <= 8'h00;
			ctl_m <= 8'h00;
			quiet <= 4'h0;
		end else begin
			sel_q <= sel;
			if (cmd_wr) cmd_m <= db_i;
			if (wr && rs == asm_pkg::RS_STAT) cmd_m <= 8'h00;
			if (ctl_wr) ctl_m <= db_i;
			if ($changed(dcd_n) || $changed(dsr_n)) quiet <= 4'h0;
			else if (quiet != 4'hf) quiet <= quiet + 4'h1;
		end
	end
	// ------
	// Checks
	// ------
	dtr_level_a: assert property (cmd_wr |=> ##1 dtr_n == !cmd_m[0])
		else $error("dtr_n wrong");
	rts_level_a: assert property (cmd_wr |=> ##1 rts_n == (cmd_m[3:2] == 2'h0))
		else $error("rts_n wrong");
	rxc_dir_a: assert property (ctl_wr |=> ##1 receive_clock_pin_oe == ctl_m[4])
		else $error("rx clock direction wrong");
	bus_drive_a: assert property (db_oe == $past(sel && rw))
		else $error("db_oe wrong");
	irq_bit_a: assert property (st_rd |=> db_o[7] == $past(irq_oe))
		else $error("irq status bit wrong");
	line_mirror_a: assert property (st_rd && quiet > 4'h6 |=>
		db_o[5] == $past(dcd_n) && db_o[6] == $past(dsr_n))
		else $error("modem line status wrong");
	modem_irq_a: assert property (cmd_m[0] && ($changed(dcd_n) || $changed(dsr_n))
		|-> ##[1:8] irq_oe)
		else $error("modem change gave no interrupt");
	reset_idle_a: assert property ($rose(rst_n) |-> txd && rts_n && dtr_n && !db_oe && !irq_oe)
		else $error("outputs not idle after reset");
endmodule // asm_sva
bind asm_modem asm_sva chk_u (.core_clk(core_clk), .rst_n(rst_n), .cs0(cs0), .cs1_n(cs1_n),
	.rs(rs), .rw(rw), .db_i(db_i), .db_o(db_o), .db_oe(db_oe), .irq_oe(irq_oe), .txd(txd),
	.receive_clock_pin_oe(receive_clock_pin_oe), .rts_n(rts_n), .dtr_n(dtr_n),
	.dsr_n(dsr_n), .dcd_n(dcd_n));
`default_nettype wire

// ==== bench/asm_peer.sv ====
// Modem-side serial model
`timescale 1ns/1ps
`default_nettype none
module asm_peer (
	input  wire logic       txd,
	input  wire logic [3:0] nd,
	input  wire logic       par_en,
	input  wire logic [3:0] div,
	output logic            rxd
);
	// ------
	// Frames
	// ------
	initial rxd = 1'b1;
	task automatic send(input logic [7:0] d, input logic bad);
		realtime bt;
		bt = 8680.556 * (div + 1);
		rxd = 1'b0;
		#(bt);
		for (int i = 0; i < nd; i++) begin
			rxd = d[i];
			#(bt);
		end
		if (par_en) begin
			rxd = ^d ^ bad;
			#(bt);
		end
		rxd = 1'b1;
		#(bt * 2);
	endtask
	task automatic recv(output logic [7:0] d, output logic ok);
		realtime bt;
		bt = 8680.556 * (div + 1);
		d = 8'h00;
		for (int k = 0; k < 3000 && txd; k++) #100;
		ok = !txd;
		#(bt / 2);
		for (int i = 0; i < nd; i++) begin
			#(bt);
			d[i] = txd;
		end
		#(bt * (par_en + 1));
		ok = ok && txd;
	endtask
endmodule // asm_peer
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench of the serial modem interface
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [1:0] a;
		logic       r;
		logic [7:0] d;
		logic [7:0] e;
	} asm_row_s;
	logic       core_clk = 1'b0;
	logic       ref_clk  = 1'b0;
	logic       rst_n, cs0, rw, rxd, txd, rxc_o, rxc_oe, cts_n, dsr_n, dcd_n, par_en, ok;
	logic       cs1_n;
	logic [1:0] rs;
	logic [3:0] nd, div;
	logic [7:0] db_i, db_o, q;
	int         num_errors, comparisons;
	asm_row_s   rows [9] = '{
		'{2'h3, 1'b0, 8'h10, 8'h00}, '{2'h3, 1'b1, 8'h00, 8'h10},
		'{2'h2, 1'b0, 8'h0b, 8'h00}, '{2'h2, 1'b1, 8'h00, 8'h0b},
		'{2'h1, 1'b1, 8'h00, 8'h10}, '{2'h1, 1'b0, 8'hff, 8'h00},
		'{2'h2, 1'b1, 8'h00, 8'h00}, '{2'h3, 1'b1, 8'h00, 8'h10},
		'{2'h2, 1'b0, 8'h0b, 8'h00}};
	always #50 core_clk = ~core_clk;
	always #271.267 ref_clk = ~ref_clk;
	asm_modem dut_u (.core_clk(core_clk), .rst_n(rst_n), .cs0(cs0), .cs1_n(cs1_n), .rs(rs),
		.rw(rw), .db_i(db_i), .db_o(db_o), .db_oe(), .irq_n_o(), .irq_oe(),
		.baud_reference_in(ref_clk), .baud_reference_out(), .rxd(rxd), .txd(txd),
		.receive_clock_pin_i(rxc_oe ? rxc_o : ref_clk), .receive_clock_pin_o(rxc_o),
		.receive_clock_pin_oe(rxc_oe), .cts_n(cts_n), .rts_n(), .dtr_n(), .dsr_n(dsr_n),
		.dcd_n(dcd_n));
	asm_peer peer_u (.txd(txd), .nd(nd), .par_en(par_en), .div(div), .rxd(rxd));
	// -----
	// Tasks
	// -----
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic [1:0] a, input logic r, input logic [7:0] d);
		@(negedge core_clk);
		cs0 = 1'b1;
		rs = a;
		rw = r;
		db_i = d;
		repeat (2) @(negedge core_clk);
		q = db_o;
		cs0 = 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		bus(a, 1'b1, 8'h00);
		chk(q, e);
	endtask
	task automatic tx(input logic [7:0] e);
		peer_u.recv(q, ok);
		chk(q, e);
		chk({7'h00, ok}, 8'h01);
	endtask
	task automatic note(input string s);
		$display("end of test %s, mismatches so far %0d", s, num_errors);
	endtask
	task automatic print_verdict;
		$display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		num_errors++;
		print_verdict();
	end
	// ----
	// Main
	// ----
	initial begin
		{rst_n, cs0, cs1_n, rs, rw, db_i, cts_n, dsr_n, dcd_n} = '0;
		{nd, par_en, div} = {4'h8, 1'b0, 4'h0};
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			bus(rows[i].a, rows[i].r, rows[i].d);
			if (rows[i].r) chk(q, rows[i].e);
		end
		note("registers");
		bus(2'h0, 1'b0, 8'ha5);
		tx(8'ha5);
		peer_u.send(8'h3c, 1'b0);
		rd(2'h1, 8'h18);
		rd(2'h0, 8'h3c);
		rd(2'h1, 8'h10);
		note("transfer");
		bus(2'h3, 1'b0, 8'h30);
		bus(2'h2, 1'b0, 8'h6b);
		{nd, par_en} = {4'h7, 1'b1};
		bus(2'h0, 1'b0, 8'hff);
		tx(8'h7f);
		peer_u.send(8'h55, 1'b1);
		rd(2'h1, 8'h19);
		rd(2'h0, 8'h55);
		peer_u.send(8'h7f, 1'b0);
		rd(2'h1, 8'h18);
		rd(2'h0, 8'h7f);
		peer_u.send(8'h11, 1'b0);
		peer_u.send(8'h22, 1'b0);
		rd(2'h1, 8'h1c);
		rd(2'h0, 8'h11);
		note("errors");
		bus(2'h3, 1'b0, 8'h10);
		bus(2'h2, 1'b0, 8'h0b);
		{nd, par_en} = {4'h8, 1'b0};
		cts_n = 1'b1;
		repeat (8) @(negedge core_clk);
		bus(2'h0, 1'b0, 8'h5a);
		peer_u.recv(q, ok);
		chk({7'h00, ok}, 8'h00);
		@(negedge core_clk);
		cts_n = 1'b0;
		tx(8'h5a);
		bus(2'h3, 1'b0, 8'h11);
		div = 4'h1;
		bus(2'h0, 1'b0, 8'hc3);
		tx(8'hc3);
		bus(2'h3, 1'b0, 8'h00);
		div = 4'h0;
		peer_u.send(8'h96, 1'b0);
		rd(2'h0, 8'h96);
		note("clocking");
		dcd_n = 1'b1;
		repeat (8) @(negedge core_clk);
		rd(2'h1, 8'hb0);
		rd(2'h1, 8'h30);
		peer_u.send(8'h44, 1'b0);
		rd(2'h1, 8'h30);
		dcd_n = 1'b0;
		dsr_n = 1'b1;
		repeat (8) @(negedge core_clk);
		rd(2'h1, 8'hd0);
		note("modem lines");
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		chk({7'h00, txd}, 8'h01);
		rst_n = 1'b1;
		rd(2'h2, 8'h00);
		rd(2'h3, 8'h00);
		cs1_n = 1'b1;
		bus(2'h3, 1'b0, 8'h55);
		cs1_n = 1'b0;
		rd(2'h3, 8'h00);
		note("reset");
		print_verdict();
	end
endmodule // tb
`default_nettype wire
